/* logic/fmpc_core.sv */
// Purpose: run-state mode selection and pulse control of a flyback controller
// Assumes: all inputs synchronous to I_CLK; registers on AHB-Lite, zero wait
// Notes: start-up, protections and zero-cross front end live elsewhere
`timescale 1ns/1ps
module fmpc_core #(
   parameter int P_WAKE_DEF_CYC = fmpc_pkg::WAKE_DEF_CYC,
   parameter int P_HALF_DEF_CYC = fmpc_pkg::HALF_DEF_CYC
) (
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   input wire logic [9:0] I_LOAD_UA,
   input wire logic [11:0] I_CLAMP_UA,
   input wire logic [11:0] I_VIN_MV,
   input wire logic [7:0] I_RTD_KOHM,
   input wire fmpc_pkg::fmpc_sense_s I_SENSE,
   output logic O_GATE,
   output logic O_REDUCED_GATE,
   output logic O_SLEEP,
   output logic O_PULLUP_EN,
   output logic O_BURST_MODE,
   output logic [5:0] O_VALLEY
);
   import fmpc_pkg::*;

   default clocking dcb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RESETN);

   logic [9:0] ld_q;
   logic [11:0] clamp_q;
   logic [11:0] vin_q;
   logic [7:0] rtd_q;
   fmpc_sense_s sense_q;
   logic ctrl_run;
   logic run_q;
   logic rtd_ok;
   logic sense_en;
   fmpc_mode_e mode;
   fmpc_mode_e next_mode;
   logic [12:0] base;
   fmpc_map_s mp;
   logic [16:0] capv;
   logic [12:0] cap_cyc;
   logic capped;
   logic [18:0] comp;
   logic [12:0] on_time;
   logic [5:0] valley_app;
   logic [5:0] low_min;
   logic [19:0] line_cnt;
   logic [19:0] half_per;
   logic synced;
   logic [19:0] vtim;
   logic vtick;
   logic [19:0] wake_per;
   logic [19:0] wake_cnt;
   logic wake_hit;
   logic [19:0] blen_cnt;
   logic [27:0] blen;
   logic pulsing;
   logic gate_on;
   logic [12:0] pcnt;
   logic [11:0] off_cnt;
   logic [5:0] zc_cnt;
   logic ahb_sel;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] st_word;

   // ----------------------------------------
   // load current mapping
   // ----------------------------------------
   function automatic fmpc_map_s map_load(input logic [9:0] ld, input logic [12:0] b);
      logic [9:0] span;
      logic [4:0] sh;
      logic [17:0] rem;
      logic [12:0] hi;
      logic [17:0] prod;
      logic [17:0] vq;
      fmpc_map_s m;
      span = (ld > MAX_PWR_UA) ? ld - MAX_PWR_UA : 10'h000;
      sh = 5'(span / HALVE_STEP_UA);
      rem = 18'(span % HALVE_STEP_UA);
      hi = b >> sh;
      // linear between halving points keeps the curve monotonic
      prod = 18'(hi >> 1) * rem;
      m.vpl = hi - 13'(prod / 18'(HALVE_STEP_UA));
      vq = (18'(span) * VALLEY_SLOPE) >> 8;
      if (vq >= 18'(MAX_VALLEY - 6'h01)) begin
         m.valley = MAX_VALLEY;
      end else begin
         m.valley = 6'(vq) + 6'h01;
      end
      if (ld >= MIN_PWR_UA) begin
         m.duty = 8'h00;
      end else if (ld < BURST_UA) begin
         m.duty = DUTY_FULL;
      end else begin
         m.duty = 8'((MIN_PWR_UA - ld) * DUTY_SLOPE);
      end
      return m;
   endfunction

   // power limit factor (Q8) and saturation offset in uA, per 100 mV
   function automatic logic [16:0] cap_tab(input logic [11:0] v);
      logic [11:0] idx;
      idx = v / 12'h064;
      case (idx)
         12'h000, 12'h001, 12'h002, 12'h003: cap_tab = {CAP_ONE, 8'h00};
         12'h004, 12'h005, 12'h006: cap_tab = {CAP_ONE, 8'h00};
         12'h007: cap_tab = {9'h0BA, 8'h17};
         12'h008: cap_tab = {9'h08C, 8'h2B};
         12'h009: cap_tab = {9'h06D, 8'h3D};
         12'h00A: cap_tab = {9'h057, 8'h4E};
         12'h00B: cap_tab = {9'h047, 8'h5C};
         12'h00C: cap_tab = {9'h03B, 8'h69};
         12'h00D: cap_tab = {9'h032, 8'h76};
         12'h00E: cap_tab = {9'h02B, 8'h81};
         12'h00F: cap_tab = {9'h025, 8'h8C};
         12'h010: cap_tab = {9'h020, 8'h95};
         12'h011: cap_tab = {9'h01C, 8'h9F};
         12'h012: cap_tab = {9'h019, 8'hA7};
         12'h013: cap_tab = {9'h016, 8'hB0};
         default: cap_tab = {9'h014, 8'hB8};
      endcase
   endfunction

   // ----------------------------------------
   // input capture
   // ----------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         ld_q <= 10'h000;
         clamp_q <= 12'h000;
         vin_q <= 12'h000;
         rtd_q <= 8'h00;
         sense_q <= '0;
      end else begin
         ld_q <= I_LOAD_UA;
         clamp_q <= I_CLAMP_UA;
         vin_q <= I_VIN_MV;
         rtd_q <= I_RTD_KOHM;
         sense_q <= I_SENSE;
      end
   end

   // resistance is judged once, when run starts
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         run_q <= 1'b0;
         rtd_ok <= 1'b0;
      end else begin
         run_q <= ctrl_run;
         if (!ctrl_run) begin
            rtd_ok <= 1'b0;
         end else if (!run_q) begin
            rtd_ok <= (rtd_q >= RTD_MIN_KOHM);
         end
      end
   end
   assign sense_en = run_q && rtd_ok;

   // ----------------------------------------
   // pulse length, cap and compensation
   // ----------------------------------------
   assign base = 13'((20'(clamp_q) * BASE_NUM) / BASE_DEN);
   assign mp = map_load(ld_q, base);
   assign capv = cap_tab(vin_q);
   assign cap_cyc = 13'((22'(base) * 22'(capv[16:8])) >> 8);
   assign capped = {1'b0, ld_q} <= 11'(MAX_PWR_UA) + 11'(capv[7:0]);
   // longer on-time per extra valley keeps power level across steps
   assign comp = 19'(mp.vpl) + 19'(mp.vpl >> 4) * 19'(valley_app - 6'h01);

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         on_time <= 13'h0000;
      end else if (capped && comp > 19'(cap_cyc)) begin
         on_time <= cap_cyc;
      end else if (comp > 19'h01FFF) begin
         on_time <= 13'h1FFF;
      end else begin
         on_time <= comp[12:0];
      end
   end

   // ----------------------------------------
   // line sync and valley update
   // ----------------------------------------
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         line_cnt <= 20'h00000;
         half_per <= 20'(P_HALF_DEF_CYC);
         synced <= 1'b0;
      end else if (sense_q.line_cross) begin
         line_cnt <= 20'h00000;
         if (sense_q.ripple_ok && mode == ST_VALLEY) begin
            synced <= 1'b1;
            half_per <= line_cnt + 20'h00001;
         end
      end else if (line_cnt != 20'hFFFFF) begin
         line_cnt <= line_cnt + 20'h00001;
      end
   end

   // unsynced, the default half cycle length P_HALF_DEF_CYC drives updates
   assign vtick = synced ? sense_q.line_cross : (vtim >= half_per - 20'h00001);

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN || vtick || mode != ST_VALLEY) begin
         vtim <= 20'h00000;
      end else begin
         vtim <= vtim + 20'h00001;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN || !sense_en) begin
         valley_app <= 6'h01;
         low_min <= MAX_VALLEY;
      end else if (mode != ST_VALLEY) begin
         valley_app <= mp.valley;
         low_min <= mp.valley;
      end else if (vtick) begin
         valley_app <= (mp.valley < low_min) ? mp.valley : low_min;
         low_min <= mp.valley;
      end else begin
         if (mp.valley < low_min) begin
            low_min <= mp.valley;
         end
         // drops and large rises act at once, small rises wait
         if (mp.valley < valley_app || mp.valley >= valley_app + VALLEY_JUMP) begin
            valley_app <= mp.valley;
         end
      end
   end

   // ----------------------------------------
   // mode selection
   // ----------------------------------------
   assign wake_per = synced ? (half_per >> 1) : 20'(P_WAKE_DEF_CYC);
   assign wake_hit = (wake_cnt >= wake_per - 20'h00001);

   always_comb begin
      next_mode = mode;
      if (!sense_en) begin
         next_mode = ST_VALLEY;
      end else begin
         case (mode)
            ST_VALLEY: begin
               if (ld_q >= BURST_UA) begin
                  next_mode = ST_SLEEP;
               end
            end
            ST_SLEEP, ST_BURST: begin
               if (sense_q.wake) begin
                  next_mode = ST_WAKE;
               end else if (wake_hit) begin
                  if (ld_q >= MIN_PWR_UA) begin
                     next_mode = ST_SLEEP;
                  end else if (ld_q < BURST_UA) begin
                     next_mode = ST_VALLEY;
                  end else begin
                     next_mode = ST_BURST;
                  end
               end else if (mode == ST_BURST && blen_cnt == 20'h00000) begin
                  next_mode = ST_SLEEP;
               end
            end
            ST_WAKE: begin
               if (sense_q.burst_end) begin
                  next_mode = ST_SLEEP;
               end
            end
            default: next_mode = ST_VALLEY;
         endcase
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         mode <= ST_VALLEY;
         O_BURST_MODE <= 1'b0;
         O_REDUCED_GATE <= 1'b0;
         O_SLEEP <= 1'b0;
      end else begin
         mode <= next_mode;
         O_BURST_MODE <= (next_mode != ST_VALLEY);
         O_REDUCED_GATE <= (next_mode != ST_VALLEY);
         O_SLEEP <= (next_mode == ST_SLEEP);
      end
   end

   // the wake timer restarts on a supply wake, so that cycle comes out long
   always_ff @(posedge I_CLK) begin
      if (!I_RESETN || mode == ST_VALLEY || wake_hit) begin
         wake_cnt <= 20'h00000;
      end else if (next_mode == ST_WAKE && mode != ST_WAKE) begin
         wake_cnt <= 20'h00000;
      end else begin
         wake_cnt <= wake_cnt + 20'h00001;
      end
   end

   assign blen = 28'(mp.duty) * 28'(wake_per);

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         blen_cnt <= 20'h00000;
      end else if (next_mode == ST_BURST && (mode != ST_BURST || wake_hit)) begin
         blen_cnt <= blen[27:8];
      end else if (blen_cnt != 20'h00000) begin
         blen_cnt <= blen_cnt - 20'h00001;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         O_PULLUP_EN <= 1'b0;
      end else begin
         O_PULLUP_EN <= run_q && next_mode != ST_WAKE;
      end
   end

   // ----------------------------------------
   // gate pulse generation
   // ----------------------------------------
   assign pulsing = sense_en && next_mode != ST_SLEEP && mode != ST_SLEEP;

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN || !pulsing) begin
         gate_on <= 1'b0;
         pcnt <= 13'h0000;
         off_cnt <= 12'h000;
         zc_cnt <= 6'h00;
      end else if (gate_on) begin
         if (pcnt + 13'h0001 >= on_time) begin
            gate_on <= 1'b0;
            pcnt <= 13'h0000;
         end else begin
            pcnt <= pcnt + 13'h0001;
         end
      end else if (zc_cnt >= valley_app || off_cnt == TOFF_MAX_CYC - 12'h001) begin
         gate_on <= 1'b1;
         off_cnt <= 12'h000;
         zc_cnt <= 6'h00;
      end else begin
         off_cnt <= off_cnt + 12'h001;
         if (sense_q.zero_cross) begin
            zc_cnt <= zc_cnt + 6'h01;
         end
      end
   end
   assign O_GATE = gate_on;
   assign O_VALLEY = valley_app;

   // ----------------------------------------
   // AHB-Lite register slave
   // ----------------------------------------
   assign ahb_sel = I_HSEL && I_HTRANS[1] && I_HREADY;

   always_comb begin
      st_word = 32'h0000_0000;
      st_word[ST_MODE_LSB +: 2] = mode;
      st_word[ST_VALLEY_LSB +: 6] = valley_app;
      st_word[ST_SENSE_BIT] = sense_en;
      st_word[ST_SYNC_BIT] = synced;
      st_word[ST_PULLUP_BIT] = O_PULLUP_EN;
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         ctrl_run <= CTRL_RST;
      end else begin
         wr_en <= ahb_sel && I_HWRITE;
         wr_addr <= I_HADDR[7:0];
         if (wr_en && wr_addr == CTRL_OFS) begin
            ctrl_run <= I_HWDATA[CTRL_RUN_BIT];
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESETN) begin
         O_HRDATA <= 32'h0000_0000;
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end else begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
         O_HRDATA <= 32'h0000_0000;
         if (ahb_sel && !I_HWRITE) begin
            case (I_HADDR[7:0])
               CTRL_OFS: O_HRDATA <= {31'h0000_0000, ctrl_run};
               STATUS_OFS: O_HRDATA <= st_word;
               LOAD_OFS: O_HRDATA <= {22'h00_0000, ld_q};
               ONTIME_OFS: O_HRDATA <= {19'h0_0000, on_time};
               default: O_HRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   mode_split_a: assert property (O_SLEEP |-> O_BURST_MODE && O_REDUCED_GATE)
      else $error("sleep outside burst mode");
   burst_entry_a: assert property (sense_en && mode == ST_VALLEY && ld_q >= BURST_UA
      |=> mode == ST_SLEEP) else $error("burst not entered at boundary");
   valley_range_a: assert property (valley_app >= 6'h01 && valley_app <= MAX_VALLEY)
      else $error("valley number out of range");
   off_limit_a: assert property (pulsing && !gate_on && off_cnt == TOFF_MAX_CYC - 12'h001
      |=> gate_on || !pulsing) else $error("off-time exceeded its cap");
   sleep_quiet_a: assert property (O_SLEEP && $past(O_SLEEP) |-> !O_GATE)
      else $error("gate active in burst pause");
   skip_a: assert property (sense_en && mode == ST_SLEEP && wake_hit && !sense_q.wake
      && ld_q >= MIN_PWR_UA |=> mode == ST_SLEEP && wake_cnt == 20'h00000)
      else $error("burst not skipped at minimum power");
   wake_prio_a: assert property (sense_en && (mode == ST_SLEEP || mode == ST_BURST)
      && sense_q.wake |=> mode == ST_WAKE)
      else $error("supply wake lost");
   pullup_off_a: assert property (mode == ST_WAKE && sense_en |-> !O_PULLUP_EN ##1 1'b1)
      else $error("pull-up on during supply wake");
   sense_gate_a: assert property (!sense_en |=> !O_GATE [*2])
      else $error("gate driven without load sensing");
   ton_cap_a: assert property (capped |=> on_time <= $past(cap_cyc))
      else $error("on-time above power limit");
   vtick_a: assert property (sense_en && mode == ST_VALLEY && next_mode == ST_VALLEY
      && vtick |=> valley_app <= $past(low_min)) else $error("valley update not from minimum");
endmodule

/* logic/fmpc_pkg.sv */
// Purpose: constants and types for the flyback mode and pulse control core
// Assumes: 50 MHz controller clock; currents are uA codes, voltages mV codes
// Notes: cycle counts are derived from the printed times and the clock rate
package fmpc_pkg;
   localparam int CLK_HZ = 32'h02FA_F080; // 50 MHz
   localparam int CLK_NS = 32'h0000_0014; // 20 ns
   // ----------------------------------------
   // load current thresholds, uA
   // ----------------------------------------
   localparam logic [9:0] MAX_PWR_UA = 10'h0D2; // 210
   localparam logic [9:0] BURST_UA = 10'h230; // 560
   localparam logic [9:0] MIN_PWR_UA = 10'h262; // 610
   localparam logic [9:0] HALVE_STEP_UA = 10'h032; // 50
   // ----------------------------------------
   // mapping constants
   // ----------------------------------------
   localparam logic [5:0] MAX_VALLEY = 6'h20; // 32
   localparam logic [5:0] VALLEY_JUMP = 6'h0A; // 10
   localparam logic [17:0] VALLEY_SLOPE = 18'h00017; // 23/256 valley per uA
   localparam logic [9:0] DUTY_SLOPE = 10'h005; // duty lsb per uA
   localparam logic [7:0] DUTY_FULL = 8'hFF;
   localparam logic [19:0] BASE_NUM = 20'h00005; // base = clamp*5/6 cycles
   localparam logic [19:0] BASE_DEN = 20'h00006;
   localparam logic [8:0] CAP_ONE = 9'h100;
   localparam logic [7:0] RTD_MIN_KOHM = 8'h1B; // 27
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int TOFF_MAX_NS = 32'h0000_B798; // 47000
   localparam logic [11:0] TOFF_MAX_CYC = 12'(TOFF_MAX_NS / CLK_NS);
   localparam int WAKE_DEF_HZ = 32'h0000_00C8; // 200
   localparam int WAKE_DEF_CYC = CLK_HZ / WAKE_DEF_HZ;
   localparam int HALF_DEF_MS = 32'h0000_000A; // 10
   localparam int HALF_DEF_CYC = HALF_DEF_MS * (CLK_HZ / 32'h0000_03E8);
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] LOAD_OFS = 8'h08;
   localparam logic [7:0] ONTIME_OFS = 8'h0C;
   localparam logic CTRL_RST = 1'h0;
   localparam int CTRL_RUN_BIT = 0;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_VALLEY_LSB = 2;
   localparam int ST_SENSE_BIT = 8;
   localparam int ST_SYNC_BIT = 9;
   localparam int ST_PULLUP_BIT = 10;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_VALLEY = 2'b00,
      ST_SLEEP = 2'b01,
      ST_BURST = 2'b10,
      ST_WAKE = 2'b11
   } fmpc_mode_e;
   typedef struct packed {
      logic wake;
      logic burst_end;
      logic zero_cross;
      logic line_cross;
      logic ripple_ok;
   } fmpc_sense_s;
   typedef struct packed {
      logic [12:0] vpl;
      logic [5:0] valley;
      logic [7:0] duty;
   } fmpc_map_s;
endpackage

/* verif/flyback_mode_pulse_control_tb_top.sv */
// Purpose: self-checking bench of the mode and pulse core
// Assumes: wake count 200, half cycle 400
// Notes: measured spans allow up to three cycles of slack, the valley off span 10 to 40 cycles
`timescale 1ns/1ps
module flyback_mode_pulse_control_tb_top;
   import fmpc_pkg::*;
   localparam int GT = 4, SL = 3, PU = 2, BM = 1;
   logic clk = 0, rst_n = 0, hsel = 0, hwr = 0, drop = 0, ring = 0;
   logic [1:0] htr = 0;
   logic [31:0] hadr = 0, hwd = 0, rd, hrd;
   logic [9:0] load = 10'h0D2, lper = 0;
   logic [11:0] clamp = 12'h4B0, vin = 12'h190;
   logic [7:0] rtd = 8'h1A;
   logic hrdy, hresp, gate, red, slp, pu, bm;
   logic [5:0] val;
   fmpc_sense_s sense;
   int failures = 0, n_compared = 0, a, b;
   wire [4:0] mon = {gate, slp, pu, bm, red};
   always #10 clk = ~clk;
   fmpc_core #(.P_WAKE_DEF_CYC(200), .P_HALF_DEF_CYC(400)) dut (
      .I_CLK(clk), .I_RESETN(rst_n), .I_HSEL(hsel), .I_HADDR(hadr), .I_HTRANS(htr),
      .I_HWRITE(hwr), .I_HSIZE(3'h2), .I_HWDATA(hwd), .I_HREADY(hrdy), .O_HRDATA(hrd),
      .O_HREADYOUT(hrdy), .O_HRESP(hresp), .I_LOAD_UA(load), .I_CLAMP_UA(clamp),
      .I_VIN_MV(vin), .I_RTD_KOHM(rtd), .I_SENSE(sense), .O_GATE(gate),
      .O_REDUCED_GATE(red), .O_SLEEP(slp), .O_PULLUP_EN(pu), .O_BURST_MODE(bm),
      .O_VALLEY(val));
   fmpc_front_model fm (.i_clk(clk), .i_gate(gate), .i_pullup_en(pu), .i_drop(drop),
      .i_ring(ring), .i_line_per(lper), .o_sense(sense));
   task automatic end_of_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %0h seen %0h", n, e, g);
      end
   endtask
   task automatic rng(input string n, input int lo, input int hi, input int g);
      n_compared++;
      if (g < lo || g > hi) begin
         failures++;
         $display("FAIL %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask
   task automatic wt(input int i, input logic v, input int lim);
      int k;
      k = 0;
      while (mon[i] !== v) begin
         @(posedge clk);
         k++;
         if (k > lim) begin
            failures++;
            $display("FAIL wait %0d expected %b seen %b", i, v, mon[i]);
            end_of_test();
         end
      end
   endtask
   task automatic span(input int i, input logic v, input int lim, output int k);
      k = 0;
      while (mon[i] === v && k < lim) begin
         @(posedge clk);
         k++;
      end
   endtask
   // single word transfer; the address phase is held until ready
   task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      int k;
      hsel <= 1'b1;
      hadr <= {24'h000000, ad};
      htr <= 2'b10;
      hwr <= w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hrdy !== 1'b1 && k < 50);
      hsel <= 1'b0;
      htr <= 2'b00;
      hwd <= d;
      do begin
         @(posedge clk);
         k++;
      end while (hrdy !== 1'b1 && k < 100);
      rd = hrd;
      chk("hresp", 0, 32'(hresp));
      if (k >= 100) begin
         failures++;
         $display("FAIL bus ready expected 1 seen %b", hrdy);
         end_of_test();
      end
   endtask
   task automatic burst_span();
      wt(SL, 1, 500);
      chk("gate asleep", 0, gate);
      wt(SL, 0, 500);
      span(SL, 0, 500, b);
      span(SL, 1, 500, a);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      ahb(0, CTRL_OFS, 0);
      chk("ctrl", 0, rd);
      ahb(1, STATUS_OFS, 32'hFFFF_FFFF);
      ahb(0, STATUS_OFS, 0);
      chk("status", 32'h0000_0004, rd);
      ahb(0, LOAD_OFS, 0);
      chk("load", {22'h000000, MAX_PWR_UA}, rd);
      ahb(0, 8'h10, 0);
      chk("unmapped", 0, rd);
      ahb(1, CTRL_OFS, 1);
      span(GT, 0, 100, a);
      chk("gate held", 100, a);
      ahb(0, STATUS_OFS, 0);
      chk("sensing", 0, rd[8]);
      ahb(1, CTRL_OFS, 0);
      rtd <= RTD_MIN_KOHM;
      ahb(1, CTRL_OFS, 1);
      repeat (10) @(posedge clk);
      ahb(0, STATUS_OFS, 0);
      chk("sensing", 1, rd[8]);
      ahb(0, ONTIME_OFS, 0);
      chk("ontime", 32'h0000_03E8, rd);
      wt(GT, 1, 5000);
      span(GT, 1, 1100, a);
      rng("on cycles", 998, 1002, a);
      span(GT, 0, 2500, a);
      rng("off cap", 2347, 2353, a);
      clamp <= 12'h258;
      repeat (5) @(posedge clk);
      ahb(0, ONTIME_OFS, 0);
      chk("ontime clamp", 32'h0000_01F4, rd);
      clamp <= 12'h4B0;
      vin <= 12'h3E8;
      repeat (5) @(posedge clk);
      ahb(0, ONTIME_OFS, 0);
      rng("ontime capped", 320, 360, rd);
      load <= 10'h136;
      repeat (900) @(posedge clk);
      ahb(0, ONTIME_OFS, 0);
      rng("ontime free", 365, 375, rd);
      vin <= 12'h190;
      load <= 10'h104;
      repeat (900) @(posedge clk);
      chk("valley", 6'h05, val);
      ahb(0, ONTIME_OFS, 0);
      chk("ontime comp", 32'h0000_0270, rd);
      load <= 10'h22F;
      repeat (900) @(posedge clk);
      chk("valley max", 6'h20, val);
      ring <= 1'b1;
      load <= 10'h0D2;
      repeat (900) @(posedge clk);
      wt(GT, 0, 3000);
      span(GT, 0, 3000, a);
      rng("valley off", 10, 40, a);
      load <= 10'h244;
      wt(BM, 1, 1000);
      chk("reduced", 1, red);
      burst_span();
      rng("pulsing", 115, 119, b);
      rng("wake period", 198, 202, a + b);
      load <= 10'h26C;
      wt(SL, 1, 500);
      span(SL, 1, 700, a);
      chk("skipped", 700, a);
      chk("pullup on", 1, pu);
      drop <= 1'b1;
      @(posedge clk);
      drop <= 1'b0;
      wt(PU, 0, 20);
      ahb(0, STATUS_OFS, 0);
      chk("supply wake", 2'h3, rd[1:0]);
      wt(PU, 1, 100);
      load <= 10'h1F4;
      wt(BM, 0, 600);
      chk("reduced off", 0, red);
      lper <= 10'h12C;
      repeat (1500) @(posedge clk);
      ahb(0, STATUS_OFS, 0);
      chk("synced", 1, rd[9]);
      load <= 10'h244;
      wt(BM, 1, 1000);
      burst_span();
      rng("synced period", 148, 152, a + b);
      end_of_test();
   end
endmodule

/* verif/fmpc_front_model.sv */
// Purpose: sense front ends and supply seen by the core
// Assumes: one clock; bench commands supply drops
// Notes: supply recharges only once the pull-up lets go
`timescale 1ns/1ps
module fmpc_front_model (
   input wire logic i_clk,
   input wire logic i_gate,
   input wire logic i_pullup_en,
   input wire logic i_drop,
   input wire logic i_ring,
   input wire logic [9:0] i_line_per,
   output fmpc_pkg::fmpc_sense_s o_sense
);
   import fmpc_pkg::*;
   logic wake = 1'b0, bend = 1'b1, zcp = 1'b0, lcp = 1'b0, rip = 1'b0;
   logic [9:0] lc = '0;
   logic [3:0] zc = '0;
   logic [4:0] chg = '0;
   assign o_sense = '{wake, bend, zcp, lcp, rip};
   // no period means a dc input: no line crossings
   always_ff @(posedge i_clk) begin
      lc <= (lc + 10'h001 >= i_line_per) ? 10'h000 : lc + 10'h001;
      lcp <= (i_line_per != 10'h000) && (lc == 10'h000);
      rip <= (i_line_per != 10'h000);
   end
   // with i_ring set, one valley every 16 cycles after turn-off
   always_ff @(posedge i_clk) begin
      zc <= i_gate ? 4'h0 : zc + 4'h1;
      zcp <= i_ring && !i_gate && (zc == 4'hF);
   end
   always_ff @(posedge i_clk) begin
      if (i_drop) begin
         wake <= 1'b1;
         bend <= 1'b0;
         chg <= 5'h00;
      end else if (wake && !i_pullup_en) begin
         chg <= chg + 5'h01;
         if (chg == 5'h13) begin
            wake <= 1'b0;
            bend <= 1'b1;
         end
      end
   end
endmodule
